// *** core/mbc_bus_ctrl.sv ***
// minimum-mode bus cycle sequencer, strobes and hold handshake
//
// Function
// - queue status appears in the cycle after the queue operation.
// - two-line queue status lets outside logic track the prefetch queue.
// - memory/io select high for memory, low for io.
// - memory/io select valid from T1 until T4 of its cycle.
// - select, write, direction and data enable float during hold acknowledge.
// - write strobe low through T2, T3 and wait states of writes.
// - interrupt acknowledge strobe low during T2, T3 and waits.
// - address latch enable high during T1 of every cycle.
// - address latch enable is always driven, even in hold.
// - direction high to transmit, low to receive, timed like memory/io select.
// - data enable asserted in every memory, io and acknowledge cycle.
// - reads and acknowledges: data enable from mid T2 to mid T3.
// - writes: data enable from start of T2 to mid T4.
// - hold acknowledge rises in a T4 or idle state.
// - bus and control outputs other than address latch enable float as hold acknowledge rises.
// - drop acknowledge on request low, drive again when a cycle is needed.
// - grant in a cycle only if request by T2, not odd low, not first ack, unlocked.
// - cycle has at least T1..T4, waits inserted between T3 and T4.
// - bus cycles start only while the strap is high; hold acknowledge and queue status ignore it.
`timescale 1ns/1ps
`include "mbc_consts.svh"
module mbc_bus_ctrl
  import mbc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic config_strap,
  input wire logic cycle_req,
  input wire mbc_pkg::mbc_kind_t cycle_kind,
  input wire logic cycle_mem,
  input wire logic cycle_odd_low,
  input wire logic cycle_first_ack,
  input wire logic lock_active,
  input wire logic ready,
  input wire logic hold_req,
  input wire logic [1:0] queue_op,
  output logic cycle_taken,
  output logic [1:0] prefetch_queue_state,
  output logic mem_io_sel,
  output logic mem_io_sel_oe_n,
  output logic write_strobe_n,
  output logic write_strobe_oe_n,
  output logic irq_ack_strobe_n,
  output logic irq_ack_strobe_oe_n,
  output logic addr_latch_en,
  output logic transceiver_direction,
  output logic transceiver_direction_oe_n,
  output logic transceiver_enable_n,
  output logic transceiver_enable_oe_n,
  output logic bus_release_ack,
  output logic bus_float
);
  import mbc_pkg::*;

  logic strap_s;
  logic hold_s;
  logic ready_s;
  mbc_state_t st_ff, nxt_st;
  mbc_kind_t kind_ff, nxt_kind;
  logic mem_ff, nxt_mem;
  logic grant_ok_ff, nxt_grant_ok;
  logic taken_ff, nxt_taken;
  logic mio_ff, nxt_mio;
  logic dtr_ff, nxt_dtr;
  logic wr_ff, nxt_wr;
  logic ia_ff, nxt_ia;
  logic ale_ff, nxt_ale;
  logic nxt_den;
  logic nxt_den_mid;
  // one register for the pin, so the two enable terms never meet in a gate at the output
  logic den_out_ff, nxt_den_out;
  logic bus_release_ack_ff, nxt_bus_release_ack;
  logic float_ff, nxt_float;
  logic [1:0] idle_cnt_ff, nxt_idle_cnt;

  // pins are asynchronous to ref_clk
  mbc_sync2 u_sync_strap (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(config_strap),
    .q(strap_s)
  );
  mbc_sync2 u_sync_hold (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(hold_req),
    .q(hold_s)
  );
  mbc_sync2 u_sync_ready (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(ready),
    .q(ready_s)
  );

  mbc_queue_status u_qs (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .queue_op(queue_op),
    .prefetch_queue_state(prefetch_queue_state)
  );

  function automatic logic is_transmit(input mbc_kind_t k);
    is_transmit = (k == MBC_WR);
  endfunction

  function automatic logic may_grant(input logic odd_low, input logic first_ack, input logic locked);
    may_grant = !odd_low && !first_ack && !locked;
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_kind = kind_ff;
    nxt_mem = mem_ff;
    nxt_grant_ok = grant_ok_ff;
    nxt_taken = 1'b0;
    nxt_bus_release_ack = bus_release_ack_ff;
    nxt_idle_cnt = idle_cnt_ff;
    case (st_ff)
      MBC_TI: begin
        if (hold_s && !lock_active) begin
          nxt_st = MBC_TH;
          nxt_bus_release_ack = 1'b1;
        end else if (cycle_req && strap_s) begin
          nxt_st = MBC_T1;
          nxt_kind = cycle_kind;
          nxt_mem = cycle_mem;
          nxt_taken = 1'b1;
          nxt_grant_ok = may_grant(cycle_odd_low, cycle_first_ack, lock_active);
        end
      end
      MBC_T1: nxt_st = MBC_T2;
      MBC_T2: begin
        nxt_st = MBC_T3;
        // request must be seen by T2
        nxt_grant_ok = grant_ok_ff && hold_s;
      end
      MBC_T3, MBC_TW: nxt_st = ready_s ? MBC_T4 : MBC_TW;
      MBC_T4: begin
        if (grant_ok_ff && hold_s) begin
          nxt_st = MBC_TH;
          nxt_bus_release_ack = 1'b1;
        end else if (cycle_req && strap_s) begin
          nxt_st = MBC_T1;
          nxt_kind = cycle_kind;
          nxt_mem = cycle_mem;
          nxt_taken = 1'b1;
          nxt_grant_ok = may_grant(cycle_odd_low, cycle_first_ack, lock_active);
        end else begin
          nxt_st = MBC_TI;
        end
      end
      MBC_TH: begin
        if (!hold_s) begin
          nxt_bus_release_ack = 1'b0;
          nxt_st = MBC_TI;
        end
      end
      default: nxt_st = MBC_TI;
    endcase
    nxt_idle_cnt = (nxt_st == MBC_TI && idle_cnt_ff != `MBC_IDLE_RESTART) ? idle_cnt_ff + 2'h1 : 2'h0;
  end

  always_comb begin
    nxt_wr = 1'b1;
    nxt_ia = 1'b1;
    nxt_den = 1'b1;
    nxt_den_mid = 1'b1;
    nxt_ale = 1'b0;
    nxt_mio = mio_ff;
    nxt_dtr = dtr_ff;
    // float while acknowledged, drive again only on a new cycle
    nxt_float = float_ff;
    if (nxt_bus_release_ack) begin
      nxt_float = 1'b1;
    end else if (nxt_st == MBC_T1) begin
      nxt_float = 1'b0;
    end
    case (nxt_st)
      MBC_T1: nxt_ale = 1'b1;
      MBC_T2, MBC_T3, MBC_TW: begin
        nxt_wr = !(nxt_kind == MBC_WR);
        nxt_ia = !(nxt_kind == MBC_IA);
        nxt_den = !is_transmit(nxt_kind);
        // read enable from mid T2, mid T3 end
        nxt_den_mid = !((nxt_st == MBC_T2) || (nxt_st == MBC_T3 && nxt_kind != MBC_WR))
                      && !(is_transmit(nxt_kind));
      end
      MBC_T4: nxt_den = !is_transmit(nxt_kind);
      default: begin
      end
    endcase
    // select and direction change at the start of T1, whether entered from T4 or from idle
    if (nxt_taken) begin
      nxt_mio = cycle_mem;
      nxt_dtr = is_transmit(cycle_kind);
    end
    nxt_den_out = nxt_den & nxt_den_mid;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= MBC_TI;
      kind_ff <= MBC_RD;
      mem_ff <= 1'b0;
      grant_ok_ff <= 1'b0;
      taken_ff <= 1'b0;
      mio_ff <= 1'b0;
      dtr_ff <= 1'b0;
      wr_ff <= 1'b1;
      ia_ff <= 1'b1;
      ale_ff <= 1'b0;
      den_out_ff <= 1'b1;
      bus_release_ack_ff <= 1'b0;
      float_ff <= 1'b0;
      idle_cnt_ff <= 2'h0;
    end else if (ce) begin
      st_ff <= nxt_st;
      kind_ff <= nxt_kind;
      mem_ff <= nxt_mem;
      grant_ok_ff <= nxt_grant_ok;
      taken_ff <= nxt_taken;
      mio_ff <= nxt_mio;
      dtr_ff <= nxt_dtr;
      wr_ff <= nxt_wr;
      ia_ff <= nxt_ia;
      ale_ff <= nxt_ale;
      den_out_ff <= nxt_den_out;
      bus_release_ack_ff <= nxt_bus_release_ack;
      float_ff <= nxt_float;
      idle_cnt_ff <= nxt_idle_cnt;
    end
  end

  // half-cycle edges of data enable are approximated by whole cycles: one clock domain only
  assign transceiver_enable_n = den_out_ff;
  assign cycle_taken = taken_ff;
  assign mem_io_sel = mio_ff;
  assign transceiver_direction = dtr_ff;
  assign write_strobe_n = wr_ff;
  assign irq_ack_strobe_n = ia_ff;
  assign addr_latch_en = ale_ff;
  assign bus_release_ack = bus_release_ack_ff;
  assign bus_float = float_ff;
  assign mem_io_sel_oe_n = float_ff;
  assign write_strobe_oe_n = float_ff;
  assign irq_ack_strobe_oe_n = float_ff;
  assign transceiver_direction_oe_n = float_ff;
  assign transceiver_enable_oe_n = float_ff;

  ale_t1_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && nxt_st == MBC_T1 |=> addr_latch_en) else $error("ale missing in T1");
  wr_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && st_ff == MBC_T1 && kind_ff == MBC_WR ##1 ce |-> !write_strobe_n) else $error("write strobe late");
  ia_strobe_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff == MBC_T2 && kind_ff == MBC_IA |-> !irq_ack_strobe_n) else $error("ack strobe missing");
  float_bus_release_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bus_release_ack |-> mem_io_sel_oe_n && write_strobe_oe_n && transceiver_enable_oe_n)
    else $error("outputs driven in hold");
  bus_release_ack_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(bus_release_ack) |-> $past(st_ff) == MBC_T4 || $past(st_ff) == MBC_TI) else $error("hold granted mid cycle");
  bus_release_ack_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && st_ff == MBC_TH && !hold_s |=> !bus_release_ack) else $error("acknowledge not dropped");
  den_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff == MBC_T4 && kind_ff == MBC_WR |-> !transceiver_enable_n) else $error("write enable gone in T4");
  den_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_ff == MBC_T4 || st_ff == MBC_T1) && kind_ff != MBC_WR |-> transceiver_enable_n) else $error("read enable late");
  min_cycle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && st_ff == MBC_T1 ##1 ce ##1 ce |-> st_ff == MBC_T3) else $error("cycle too short");

  // strobes and selects against the state they belong to
  ale_only_t1_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    addr_latch_en |-> st_ff == MBC_T1)
    else $error("ale outside T1");
  mio_stable_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff inside {MBC_T2, MBC_T3, MBC_TW} |=> $stable(mem_io_sel))
    else $error("select changed mid cycle");
  dtr_stable_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff inside {MBC_T2, MBC_T3, MBC_TW} |=> $stable(transceiver_direction))
    else $error("direction changed mid cycle");
  mio_value_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && nxt_taken |=> mem_io_sel == $past(cycle_mem))
    else $error("select value wrong");
  dtr_value_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && nxt_taken |=> transceiver_direction == ($past(cycle_kind) == MBC_WR))
    else $error("direction value wrong");
  wr_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff inside {MBC_TI, MBC_T1, MBC_T4, MBC_TH} |-> write_strobe_n)
    else $error("write strobe outside T2 to TW");
  ia_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff inside {MBC_TI, MBC_T1, MBC_T4, MBC_TH} |-> irq_ack_strobe_n)
    else $error("ack strobe outside T2 to TW");
  den_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff inside {MBC_TI, MBC_T1, MBC_TH} |-> transceiver_enable_n)
    else $error("data enable outside cycle");
  qs_delay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce |=> prefetch_queue_state == $past(queue_op))
    else $error("queue status not one cycle late");
  strap_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && !strap_s && st_ff == MBC_TI |=> !cycle_taken)
    else $error("cycle started with strap low");
  den_wr_t2_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff == MBC_T2 && kind_ff == MBC_WR |-> !transceiver_enable_n)
    else $error("write enable missing in T2");
  bus_release_ack_float_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(bus_release_ack) |-> bus_float)
    else $error("bus not floated with acknowledge");
  wr_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff == MBC_TW && kind_ff == MBC_WR |-> !write_strobe_n)
    else $error("write strobe gone in wait");
  ia_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff == MBC_TW && kind_ff == MBC_IA |-> !irq_ack_strobe_n)
    else $error("ack strobe gone in wait");
  t1_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff == MBC_T1 |-> !bus_float && !bus_release_ack)
    else $error("cycle run while floating");
  hold_oe_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bus_release_ack |-> irq_ack_strobe_oe_n && transceiver_direction_oe_n)
    else $error("strobe or direction driven in hold");
endmodule

// *** core/mbc_consts.svh ***
// constants for the minimum-mode bus control block
`ifndef MBC_CONSTS_SVH
`define MBC_CONSTS_SVH
`define MBC_QS_NOP 2'h0
`define MBC_QS_FIRST 2'h1
`define MBC_QS_EMPTY 2'h2
`define MBC_QS_SUBSEQ 2'h3
`define MBC_MIN_STATES 3'h4
`define MBC_IDLE_RESTART 2'h3
`endif

// *** core/mbc_pkg.sv ***
// types for the minimum-mode bus control block
package mbc_pkg;
  typedef enum logic [2:0] {
    MBC_TI = 3'h0,
    MBC_T1 = 3'h1,
    MBC_T2 = 3'h2,
    MBC_T3 = 3'h3,
    MBC_TW = 3'h4,
    MBC_T4 = 3'h5,
    MBC_TH = 3'h6
  } mbc_state_t;
  typedef enum logic [1:0] {
    MBC_RD = 2'h0,
    MBC_WR = 2'h1,
    MBC_IA = 2'h2
  } mbc_kind_t;
endpackage

// *** core/mbc_queue_status.sv ***
// queue status register, shown the cycle after the queue operation
`timescale 1ns/1ps
`include "mbc_consts.svh"
module mbc_queue_status (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [1:0] queue_op,
  output logic [1:0] prefetch_queue_state
);
  logic [1:0] qs_ff;
  logic [1:0] nxt_qs;
  always_comb begin
    nxt_qs = queue_op;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      qs_ff <= `MBC_QS_NOP;
    end else if (ce) begin
      qs_ff <= nxt_qs;
    end
  end
  assign prefetch_queue_state = qs_ff;
endmodule

// *** core/mbc_sync2.sv ***
// two-flop synchroniser for a pin input
`timescale 1ns/1ps
module mbc_sync2 (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic meta_ff;
  logic q_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end else if (ce) begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule

// *** tb/mbc_far_side.sv ***
// far-side model: ready source and alternate bus master
`timescale 1ns/1ps
module mbc_far_side (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic want_bus,
  input wire logic addr_latch_en,
  input wire logic bus_release_ack,
  output logic ready,
  output logic hold_req
);
  logic [1:0] wait_ff;
  // launched on the falling edge, so set-up to the rising edge is assured
  always_ff @(negedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 2'h0;
      ready <= 1'h1;
      hold_req <= 1'h0;
    end else begin
      if (slow && addr_latch_en) wait_ff <= 2'h3;
      else if (wait_ff != 2'h0) wait_ff <= wait_ff - 2'h1;
      ready <= !(slow && (addr_latch_en || wait_ff != 2'h0));
      hold_req <= want_bus;
    end
  end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the minimum-mode bus control block
`timescale 1ns/1ps
module testbench;
  import mbc_pkg::*;
  logic ref_clk = 1'h0, rst_n = 1'h0, ce = 1'h1, config_strap = 1'h1, cycle_req = 1'h0;
  mbc_kind_t cycle_kind = MBC_RD;
  logic cycle_mem = 1'h0, cycle_odd_low = 1'h0, cycle_first_ack = 1'h0, lock_active = 1'h0;
  logic [1:0] queue_op = 2'h0;
  logic slow = 1'h0, want_bus = 1'h0, ready, hold_req, cycle_taken, mem_io_sel, mem_io_sel_oe_n;
  logic write_strobe_n, write_strobe_oe_n, irq_ack_strobe_n, irq_ack_strobe_oe_n, addr_latch_en;
  logic transceiver_direction, transceiver_direction_oe_n, transceiver_enable_n;
  logic transceiver_enable_oe_n, bus_release_ack, bus_float;
  logic [1:0] prefetch_queue_state;
  int num_errors = 0, num_checks = 0, cyc = 0, seed = 32'h0d7b;
  logic [1:0] q_exp[$];
  logic [2:0] c_exp[$];

  always #50 ref_clk = ~ref_clk;

  mbc_bus_ctrl mbc_bus_ctrl_i (.*);
  mbc_far_side mbc_far_side_i (.*);

  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    num_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // cycle ceiling well above the whole sequence
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  always @(posedge ref_clk) begin
    #1;
    if (q_exp.size() > 0) check(prefetch_queue_state, q_exp.pop_front());
  end

  // a taken request with no note pending is an error too
  always @(posedge ref_clk) begin : watch_cycle
    logic [2:0] e;
    #1;
    if (cycle_taken === 1'h1) begin
      check(c_exp.size() > 0, 1'h1);
      e = c_exp.pop_front();
      check(addr_latch_en, 1'h1);
      check(mem_io_sel, e[0]);
      check(transceiver_direction, e[2:1] == MBC_WR);
      @(posedge ref_clk);
      #1;
      check(write_strobe_n, e[2:1] != MBC_WR);
      check(irq_ack_strobe_n, e[2:1] != MBC_IA);
      check(transceiver_enable_n, 1'h0);
    end
  end

  // request held until the taken pulse, then dropped
  task automatic bus(input mbc_kind_t k);
    int i;
    @(negedge ref_clk);
    cycle_req = 1'h1;
    cycle_kind = k;
    cycle_mem = 1'($random(seed));
    cycle_odd_low = 1'($random(seed));
    cycle_first_ack = 1'($random(seed));
    c_exp.push_back({k, cycle_mem});
    for (i = 0; i < 20 && cycle_taken !== 1'h1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check(cycle_taken, 1'h1);
    @(negedge ref_clk);
    cycle_req = 1'h0;
  endtask

  task automatic wait_ack(input logic v);
    int i;
    for (i = 0; i < 10 && bus_release_ack !== v; i++) @(negedge ref_clk);
    check(bus_release_ack, v);
  endtask

  initial begin
    repeat (16) @(negedge ref_clk);
    rst_n = 1'h1;
    repeat (3) @(negedge ref_clk);
    repeat (40) begin
      @(negedge ref_clk);
      queue_op = 2'($random(seed));
      q_exp.push_back(queue_op);
    end
    $display("test queue status done");
    for (int s = 0; s < 2; s++) begin
      slow <= 1'(s);
      for (int k = 0; k < 3; k++) repeat (3) bus(mbc_kind_t'(k));
    end
    $display("test bus cycles done");
    config_strap = 1'h0;
    repeat (4) @(negedge ref_clk);
    cycle_req = 1'h1;
    repeat (6) @(negedge ref_clk);
    config_strap = 1'h1;
    bus(MBC_WR);
    $display("test strap low done");
    // lock keeps the bus even in idle
    lock_active = 1'h1;
    want_bus <= 1'h1;
    repeat (8) @(negedge ref_clk);
    check(bus_release_ack, 1'h0);
    lock_active = 1'h0;
    wait_ack(1'h1);
    check({mem_io_sel_oe_n, write_strobe_oe_n, transceiver_direction_oe_n, transceiver_enable_oe_n}, 4'hf);
    check(irq_ack_strobe_oe_n, 1'h1);
    check(addr_latch_en, 1'h0);
    cycle_req = 1'h1;
    repeat (6) @(negedge ref_clk);
    check(bus_release_ack, 1'h1);
    // frozen clock enable: the dropped request must not be seen yet
    ce = 1'h0;
    want_bus <= 1'h0;
    repeat (6) @(negedge ref_clk);
    check(bus_release_ack, 1'h1);
    ce = 1'h1;
    bus(MBC_RD);
    check(bus_release_ack, 1'h0);
    $display("test hold done");
    repeat (6) @(negedge ref_clk);
    tally_and_finish();
  end
endmodule
